// ==== core/elg_capture.sv ====
// Encoder latch, gate, status input and output switching with APB access
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module elg_capture (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder counter and velocity
  input wire logic [31:0] counterValue,
  input wire logic [31:0] velocityValue,
  output logic counterFreeze,
  // Trigger and status pins
  input wire logic latchExtPin,
  input wire logic gateLatchPin,
  input wire logic statusPin,
  input wire logic overvoltagePin,
  output logic statusLedRed,
  // Diagnostic record
  output logic diagRecordValid,
  output logic [15:0] diagRecordCode,
  // Digital outputs
  output logic [1:0] digOut,
  output logic [1:0] digOutOe
);
  // ==========================================================
  // Declarations
  logic [2:0] extSync;
  logic [2:0] gateSync;
  logic [1:0] statSync;
  logic [1:0] ovvSync;
  logic ovvLast;
  logic [31:0] ctrl;
  logic [31:0] outCfg;
  logic [15:0] thrMask;
  logic [31:0] pulseLen;
  logic [31:0] thr [elg_pkg::NUM_THR];
  logic [31:0] velOn;
  logic [31:0] velOff;
  logic [31:0] latch1;
  logic [31:0] latch2;
  logic extValid;
  logic ext2Valid;
  logic [1:0] extOwner;
  logic [1:0] ext2Owner;
  logic extDone;
  logic ext2Done;
  logic statusErr;
  logic [31:0] next_prdata;
  logic mapped;
  logic wrEn;
  logic rise1;
  logic fall1;
  logic rise2;
  logic fall2;
  logic hit1;
  logic hit2;
  logic [1:0] en1;
  logic [1:0] en2;
  logic ovvEvent;
  logic diagClr;
  logic [1:0] countState;
  logic [1:0] velState;
  logic [31:0] pulseCnt [elg_pkg::NUM_OUT];
  logic [1:0] next_level;
  elg_pkg::elg_gate_t gatePol;

  // ==========================================================
  // Input synchronisers and edge detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extSync <= 3'h0;
      gateSync <= 3'h0;
      statSync <= 2'h3;
      ovvSync <= 2'h0;
      ovvLast <= 1'b0;
    end else begin
      extSync <= {extSync[1:0], latchExtPin};
      gateSync <= {gateSync[1:0], gateLatchPin};
      statSync <= {statSync[0], statusPin};
      ovvSync <= {ovvSync[0], overvoltagePin};
      ovvLast <= ovvSync[1];
    end
  end

  assign rise1 = extSync[1] & ~extSync[2];
  assign fall1 = ~extSync[1] & extSync[2];
  assign rise2 = gateSync[1] & ~gateSync[2];
  assign fall2 = ~gateSync[1] & gateSync[2];
  assign ovvEvent = ovvSync[1] & ~ovvLast;
  assign en1 = {ctrl[elg_pkg::EXT_NEG_BIT], ctrl[elg_pkg::EXT_POS_BIT]};
  assign en2 = {ctrl[elg_pkg::EXT2_NEG_BIT], ctrl[elg_pkg::EXT2_POS_BIT]};
  assign gatePol = elg_pkg::elg_gate_t'(ctrl[elg_pkg::GATE_POL_LSB +: 2]);

  // Owned edge hits for each capture channel
  assign hit1 = (extOwner[0] & rise1) | (extOwner[1] & fall1);
  assign hit2 = (ext2Owner[0] & rise2) | (ext2Owner[1] & fall2);

  // ==========================================================
  // APB decode
  assign wrEn = psel & penable & pready & pwrite;
  assign diagClr = wrEn & (paddr == elg_pkg::DIAG_OFS) &
    pwdata[elg_pkg::DIAG_CLR_BIT];

  always_comb begin
    next_prdata = elg_pkg::RESET_WORD;
    mapped = 1'b1;
    case (paddr)
      elg_pkg::CTRL_OFS: next_prdata = ctrl;
      elg_pkg::STATUS_OFS: begin
        next_prdata[elg_pkg::STAT_EXT_VALID_BIT] = extValid;
        next_prdata[elg_pkg::STAT_EXT2_VALID_BIT] = ext2Valid;
        next_prdata[elg_pkg::STAT_EXT_LEVEL_BIT] = extSync[1];
        next_prdata[elg_pkg::STAT_GATE_LEVEL_BIT] = gateSync[1];
        next_prdata[elg_pkg::STAT_INPUT_BIT] = statSync[1];
        next_prdata[elg_pkg::STAT_ERR_BIT] = statusErr;
        next_prdata[elg_pkg::STAT_FREEZE_BIT] = counterFreeze;
        next_prdata[elg_pkg::STAT_OUT_LSB +: elg_pkg::NUM_OUT] = digOut;
      end
      elg_pkg::LATCH1_OFS: next_prdata = latch1;
      elg_pkg::LATCH2_OFS: next_prdata = latch2;
      elg_pkg::DIAG_OFS: begin
        next_prdata[15:0] = diagRecordCode;
        next_prdata[elg_pkg::DIAG_ERR_BIT] = statusErr;
      end
      elg_pkg::OUTCFG_OFS: next_prdata = outCfg;
      elg_pkg::THRMASK_OFS: next_prdata = {16'h0000, thrMask};
      elg_pkg::PULSE_OFS: next_prdata = pulseLen;
      elg_pkg::VELON_OFS: next_prdata = velOn;
      elg_pkg::VELOFF_OFS: next_prdata = velOff;
      default: begin
        if (paddr >= elg_pkg::THR_OFS && paddr < elg_pkg::VELON_OFS &&
            paddr[1:0] == 2'h0) begin
          next_prdata = thr[paddr[2 +: elg_pkg::THR_IDX_W]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // Bus answer one cycle after setup
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= elg_pkg::RESET_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      prdata <= (psel & ~penable & ~pwrite) ? next_prdata : prdata;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // ==========================================================
  // Software written configuration
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= elg_pkg::RESET_WORD;
      outCfg <= elg_pkg::RESET_WORD;
      thrMask <= 16'h0000;
      pulseLen <= elg_pkg::RESET_WORD;
      velOn <= elg_pkg::RESET_WORD;
      velOff <= elg_pkg::RESET_WORD;
    end else if (wrEn) begin
      case (paddr)
        elg_pkg::CTRL_OFS: ctrl <= pwdata;
        elg_pkg::OUTCFG_OFS: outCfg <= pwdata;
        elg_pkg::THRMASK_OFS: thrMask <= pwdata[15:0];
        elg_pkg::PULSE_OFS: pulseLen <= pwdata;
        elg_pkg::VELON_OFS: velOn <= pwdata;
        elg_pkg::VELOFF_OFS: velOff <= pwdata;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Counter threshold table
  generate
    for (genvar i = 0; i < elg_pkg::NUM_THR; i++) begin : gThr
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          thr[i] <= elg_pkg::RESET_WORD;
        end else if (wrEn && paddr == elg_pkg::THR_OFS + 8'(4 * i)) begin
          thr[i] <= pwdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Primary capture channel from the external latch input
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extOwner <= 2'h0;
      extDone <= 1'b0;
      extValid <= 1'b0;
      latch1 <= elg_pkg::RESET_WORD;
    end else if (en1 == 2'h0) begin
      extOwner <= 2'h0;
      extDone <= 1'b0;
      extValid <= 1'b0;
    end else begin
      if (extOwner == 2'h0 && !extDone) begin
        extOwner <= en1;
      end
      if (hit1) begin
        latch1 <= counterValue;
        extValid <= 1'b1;
        if (!ctrl[elg_pkg::CONT_EXT_BIT]) begin
          extOwner <= 2'h0;
          extDone <= 1'b1;
        end
      end
    end
  end

  // Secondary capture channel from the gate/latch input
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext2Owner <= 2'h0;
      ext2Done <= 1'b0;
      ext2Valid <= 1'b0;
      latch2 <= elg_pkg::RESET_WORD;
    end else if (en2 == 2'h0) begin
      ext2Owner <= 2'h0;
      ext2Done <= 1'b0;
      ext2Valid <= 1'b0;
    end else begin
      if (ext2Owner == 2'h0 && !ext2Done) begin
        ext2Owner <= en2;
      end
      if (hit2) begin
        latch2 <= counterValue;
        ext2Valid <= 1'b1;
        if (!ctrl[elg_pkg::CONT_EXT2_BIT]) begin
          ext2Owner <= 2'h0;
          ext2Done <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Gate: freeze follows the same sample that captures
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counterFreeze <= 1'b0;
    end else begin
      case (gatePol)
        elg_pkg::GATE_HIGH: counterFreeze <= gateSync[1];
        elg_pkg::GATE_LOW: counterFreeze <= ~gateSync[1];
        default: counterFreeze <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Overvoltage diagnosis, set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      statusErr <= 1'b0;
    end else if (ovvEvent) begin
      statusErr <= 1'b1;
    end else if (diagClr) begin
      statusErr <= 1'b0;
    end
  end

  // Diagnostic record pulse and text code
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      diagRecordValid <= 1'b0;
      diagRecordCode <= 16'h0000;
    end else begin
      diagRecordValid <= ovvEvent;
      if (ovvEvent) begin
        diagRecordCode <= elg_pkg::DIAG_STATUS_OVV;
      end
    end
  end

  // Red indicator on alarm low or overvoltage
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      statusLedRed <= 1'b0;
    end else begin
      statusLedRed <= ~statSync[1] | statusErr | ovvSync[1];
    end
  end

  // ==========================================================
  // Counter threshold state: highest enabled threshold reached
  always_comb begin
    countState = 2'h0;
    for (int k = 0; k < elg_pkg::NUM_THR; k++) begin
      if (thrMask[elg_pkg::NUM_THR + k] && counterValue >= thr[k]) begin
        countState = {2{thrMask[k]}};
      end
    end
  end

  // Velocity hysteresis: first threshold on, second off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      velState <= 2'h0;
    end else if (velocityValue >= velOn) begin
      velState <= 2'h3;
    end else if (velocityValue <= velOff) begin
      velState <= 2'h0;
    end
  end

  // ==========================================================
  // Two independent digital outputs
  generate
    for (genvar o = 0; o < elg_pkg::NUM_OUT; o++) begin : gOut
      always_comb begin
        case (elg_pkg::elg_func_t'(outCfg[elg_pkg::FUNC0_LSB + 2 * o +: 2]))
          elg_pkg::FUNC_COUNT: next_level[o] = countState[o] &
            (pulseLen == elg_pkg::RESET_WORD || pulseCnt[o] < pulseLen);
          elg_pkg::FUNC_VELO: next_level[o] = velState[o];
          default: next_level[o] = outCfg[elg_pkg::MANUAL_LSB + o];
        endcase
      end

      // Timed switching counts how long the threshold state holds
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          pulseCnt[o] <= elg_pkg::RESET_WORD;
        end else if (!countState[o]) begin
          pulseCnt[o] <= elg_pkg::RESET_WORD;
        end else if (pulseCnt[o] < pulseLen) begin
          pulseCnt[o] <= pulseCnt[o] + 32'h1;
        end
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          digOut[o] <= 1'b0;
          digOutOe[o] <= 1'b0;
        end else begin
          digOut[o] <= next_level[o];
          digOutOe[o] <= next_level[o] |
            ~outCfg[elg_pkg::MODE_LSB + o];
        end
      end
    end
  endgenerate
endmodule : elg_capture

// ==== core/elg_pkg.sv ====
// Package for the encoder latch and gate capture block
package elg_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LATCH1_OFS = 8'h08;
  localparam logic [7:0] LATCH2_OFS = 8'h0c;
  localparam logic [7:0] DIAG_OFS = 8'h10;
  localparam logic [7:0] OUTCFG_OFS = 8'h14;
  localparam logic [7:0] THRMASK_OFS = 8'h18;
  localparam logic [7:0] PULSE_OFS = 8'h1c;
  localparam logic [7:0] THR_OFS = 8'h20;
  localparam logic [7:0] VELON_OFS = 8'h40;
  localparam logic [7:0] VELOFF_OFS = 8'h44;
  // ==========================================================
  // Control and diagnostic register field positions
  localparam int EXT_POS_BIT = 0;
  localparam int EXT_NEG_BIT = 1;
  localparam int EXT2_POS_BIT = 2;
  localparam int EXT2_NEG_BIT = 3;
  localparam int CONT_EXT_BIT = 4;
  localparam int CONT_EXT2_BIT = 5;
  localparam int GATE_POL_LSB = 6;
  localparam int DIAG_CLR_BIT = 0;
  localparam int DIAG_ERR_BIT = 16;
  // ==========================================================
  // Status register field positions
  localparam int STAT_EXT_VALID_BIT = 0;
  localparam int STAT_EXT2_VALID_BIT = 1;
  localparam int STAT_EXT_LEVEL_BIT = 2;
  localparam int STAT_GATE_LEVEL_BIT = 3;
  localparam int STAT_INPUT_BIT = 4;
  localparam int STAT_ERR_BIT = 5;
  localparam int STAT_FREEZE_BIT = 6;
  localparam int STAT_OUT_LSB = 7;
  // ==========================================================
  // Output configuration field positions, output and threshold counts
  localparam int MODE_LSB = 0;
  localparam int MANUAL_LSB = 2;
  localparam int FUNC0_LSB = 4;
  localparam int FUNC1_LSB = 6;
  localparam int NUM_OUT = 2;
  localparam int NUM_THR = 8;
  localparam int THR_IDX_W = 3;
  // ==========================================================
  // Constants and modes
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] DIAG_STATUS_OVV = 16'h8315;
  typedef enum logic [1:0] {
    GATE_OFF = 2'b00,
    GATE_HIGH = 2'b01,
    GATE_LOW = 2'b10
  } elg_gate_t;
  typedef enum logic [1:0] {
    FUNC_MANUAL = 2'b00,
    FUNC_COUNT = 2'b01,
    FUNC_VELO = 2'b10
  } elg_func_t;
endpackage : elg_pkg

// ==== dv/elg_capture_chk.sv ====
// Port checker for the capture block
`timescale 1ns/1ns
module elg_capture_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status input and diagnostics
  input wire logic statusPin,
  input wire logic overvoltagePin,
  input wire logic statusLedRed,
  input wire logic diagRecordValid,
  input wire logic [15:0] diagRecordCode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Bus answers
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready && penable)
    else $error("error outside access");
  chk_read_data: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside read");
  // ==========================================================
  // Status input and overvoltage
  chk_alarm_red: assert property (
    $fell(statusPin) |-> ##[1:4] statusLedRed)
    else $error("alarm low without red");
  chk_ovv_record: assert property (
    $rose(overvoltagePin) |-> ##[1:4] diagRecordValid)
    else $error("overvoltage without record");
  chk_record_pulse: assert property (
    diagRecordValid |=> !diagRecordValid)
    else $error("record pulse too long");
  chk_record_code: assert property (
    diagRecordValid |=> diagRecordCode == elg_pkg::DIAG_STATUS_OVV)
    else $error("wrong record code");
  chk_ovv_red: assert property (
    diagRecordValid |-> ##[0:2] statusLedRed)
    else $error("overvoltage without red");
  cover property (diagRecordValid);
  cover property (pslverr);
  cover property ($fell(statusPin));
endmodule : elg_capture_chk

bind elg_capture elg_capture_chk CHK (.mclk, .reset_n, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .statusPin, .overvoltagePin,
  .statusLedRed, .diagRecordValid, .diagRecordCode);

// ==== dv/elg_pins.sv ====
// Trigger pins and encoder alarm line model
`timescale 1ns/1ns
module elg_pins (
  // Clock
  input wire logic mclk,
  // Pins toward the block
  output logic latchExtPin,
  output logic gateLatchPin,
  output logic statusPin,
  output logic overvoltagePin
);
  logic alarmLow;
  // Open alarm output reads high through the pull-up
  assign statusPin = !alarmLow;
  initial begin
    latchExtPin = 1'b0;
    gateLatchPin = 1'b0;
    alarmLow = 1'b0;
    overvoltagePin = 1'b0;
  end
  // Drive one line, then hold it past the minimum pulse time
  task automatic drive(input int sel, input logic lvl);
    @(posedge mclk);
    case (sel)
      0: latchExtPin <= lvl;
      1: gateLatchPin <= lvl;
      2: alarmLow <= lvl;
      default: overvoltagePin <= lvl;
    endcase
    repeat (110) @(posedge mclk);
  endtask : drive
endmodule : elg_pins

// ==== dv/test_encoder_latch_gate_capture.sv ====
// Self-checking bench for the capture block
`timescale 1ns/1ns
module test_encoder_latch_gate_capture;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic counterFreeze, latchExtPin, gateLatchPin, statusPin;
  logic overvoltagePin, statusLedRed, diagRecordValid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, counterValue, velocityValue, rd;
  logic [15:0] diagRecordCode;
  logic [1:0] digOut, digOutOe;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  elg_capture DUT (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .counterValue, .velocityValue,
    .counterFreeze, .latchExtPin, .gateLatchPin, .statusPin,
    .overvoltagePin, .statusLedRed, .diagRecordValid, .diagRecordCode,
    .digOut, .digOutOe);
  elg_pins PINS (.mclk, .latchExtPin, .gateLatchPin, .statusPin,
    .overvoltagePin);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // Verdict, compare and bus tasks
  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask : rdchk
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, elg_pkg::CTRL_OFS, d);
  endtask : ctl
  // Drive a trigger pin, then read latch, freeze and pin level
  task automatic cap(input int ch, input logic lvl, input logic [31:0] cnt,
      input logic [31:0] exp, input logic frz);
    counterValue <= cnt;
    PINS.drive(ch, lvl);
    rdchk(elg_pkg::LATCH1_OFS + 8'(4 * ch), exp);
    cmp({31'h0, counterFreeze}, {31'h0, frz});
    apb(1'b0, elg_pkg::STATUS_OFS, 32'h0);
    cmp({31'h0, rd[2 + ch]}, {31'h0, lvl});
  endtask : cap
  task automatic outs(input logic [1:0] v, input logic [1:0] oe);
    repeat (3) @(posedge mclk);
    cmp({30'h0, digOut}, {30'h0, v});
    cmp({30'h0, digOutOe}, {30'h0, oe});
  endtask : outs
  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    counterValue = 32'h0;
    velocityValue = 32'h0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdchk(elg_pkg::STATUS_OFS, 32'h10);
    rdchk(8'h80, 32'h0);
    cmp({31'h0, err}, 32'h1);
    ctl(32'h1);
    cap(0, 1'b1, 32'h11, 32'h11, 1'b0);
    cap(0, 1'b0, 32'h22, 32'h11, 1'b0);
    cap(0, 1'b1, 32'h33, 32'h11, 1'b0);
    rdchk(elg_pkg::STATUS_OFS, 32'h15);
    ctl(32'h0);
    rdchk(elg_pkg::STATUS_OFS, 32'h14);
    ctl(32'h2);
    cap(0, 1'b0, 32'h44, 32'h44, 1'b0);
    ctl(32'h0);
    ctl(32'h13);
    cap(0, 1'b1, 32'h55, 32'h55, 1'b0);
    cap(0, 1'b0, 32'h66, 32'h66, 1'b0);
    ctl(32'h0);
    cap(0, 1'b1, 32'h67, 32'h66, 1'b0);
    ctl(32'h1);
    ctl(32'h3);
    cap(0, 1'b0, 32'h70, 32'h66, 1'b0);
    cap(0, 1'b1, 32'h71, 32'h71, 1'b0);
    ctl(32'h2);
    cap(0, 1'b0, 32'h72, 32'h71, 1'b0);
    ctl(32'h0);
    ctl(32'h2);
    cap(0, 1'b1, 32'h73, 32'h71, 1'b0);
    cap(0, 1'b0, 32'h74, 32'h74, 1'b0);
    ctl(32'h0);
    ctl(32'h64);
    cap(1, 1'b1, 32'h77, 32'h77, 1'b1);
    cap(1, 1'b0, 32'h88, 32'h77, 1'b0);
    cap(1, 1'b1, 32'h99, 32'h99, 1'b1);
    ctl(32'h0);
    ctl(32'h8c);
    cap(1, 1'b0, 32'h91, 32'h91, 1'b1);
    cap(1, 1'b1, 32'h92, 32'h91, 1'b0);
    ctl(32'h0);
    rdchk(elg_pkg::STATUS_OFS, 32'h18);
    PINS.drive(2, 1'b1);
    rdchk(elg_pkg::STATUS_OFS, 32'h08);
    cmp({31'h0, statusLedRed}, 32'h1);
    PINS.drive(2, 1'b0);
    cmp({31'h0, statusLedRed}, 32'h0);
    PINS.drive(3, 1'b1);
    rdchk(elg_pkg::DIAG_OFS, 32'h18315);
    cmp({31'h0, statusLedRed}, 32'h1);
    PINS.drive(3, 1'b0);
    apb(1'b1, elg_pkg::DIAG_OFS, 32'h1);
    rdchk(elg_pkg::DIAG_OFS, 32'h8315);
    cmp({31'h0, statusLedRed}, 32'h0);
    apb(1'b1, elg_pkg::OUTCFG_OFS, 32'h06);
    outs(2'h1, 2'h1);
    apb(1'b1, elg_pkg::OUTCFG_OFS, 32'h0e);
    outs(2'h3, 2'h3);
    apb(1'b1, elg_pkg::THR_OFS, 32'h100);
    apb(1'b1, elg_pkg::THR_OFS + 8'h4, 32'h200);
    apb(1'b1, elg_pkg::THRMASK_OFS, 32'h301);
    apb(1'b1, elg_pkg::OUTCFG_OFS, 32'h50);
    counterValue <= 32'h150;
    outs(2'h3, 2'h3);
    counterValue <= 32'h250;
    outs(2'h0, 2'h3);
    apb(1'b1, elg_pkg::PULSE_OFS, 32'h4);
    counterValue <= 32'h150;
    outs(2'h3, 2'h3);
    outs(2'h0, 2'h3);
    apb(1'b1, elg_pkg::VELON_OFS, 32'h64);
    apb(1'b1, elg_pkg::VELOFF_OFS, 32'h32);
    apb(1'b1, elg_pkg::OUTCFG_OFS, 32'ha0);
    velocityValue <= 32'h28;
    outs(2'h0, 2'h3);
    velocityValue <= 32'h46;
    outs(2'h0, 2'h3);
    velocityValue <= 32'h78;
    outs(2'h3, 2'h3);
    velocityValue <= 32'h46;
    outs(2'h3, 2'h3);
    velocityValue <= 32'h28;
    outs(2'h0, 2'h3);
    conclude();
  end
endmodule : test_encoder_latch_gate_capture
